// >>> gfc_pkg.sv
`default_nettype none
package gfc_pkg;
  // device register offsets
  localparam logic [6:0] GFC_LEGACY_OFS = 7'h0d;
  localparam logic [6:0] GFC_CHAIN_OFS = 7'h0e;
  localparam logic [6:0] GFC_GAIN_OFS = 7'h0f;
  localparam logic [6:0] GFC_FILTER_OFS = 7'h10;
  localparam logic [6:0] GFC_CAL_OFS = 7'h11;
  // reset values
  localparam logic [7:0] GFC_GAIN_RST = 8'h00;
  localparam logic [1:0] GFC_LEGACY_RST = 2'h0;
  localparam logic [7:0] GFC_CHAIN_RST = 8'h02;
  localparam logic GFC_IIR_RST = 1'b0;
  localparam logic GFC_AUTO_CALIBRATE_DISABLE_RST = 1'b0;
  // field positions
  localparam int GFC_TXM_BIT = 7;
  localparam int GFC_RXM_BIT = 3;
  localparam int GFC_IIR_BIT = 4;
  localparam int GFC_MANUAL_CALIBRATE_BIT_BIT = 6;
  localparam int GFC_AUTO_CALIBRATE_DISABLE_BIT = 5;
  localparam int GFC_CHAIN_BIT = 0;
  localparam logic [3:0] GFC_FILTER_NIBBLE = 4'h8;
  // serial timing: half bit clock is 16 clocks, frame is 32 bit clocks
  localparam logic [3:0] GFC_DIV_LAST = 4'hf;
  localparam logic [4:0] GFC_FRAME_LAST = 5'h1f;
  localparam logic [4:0] GFC_DATA_LAST = 5'h0f;
  localparam logic [4:0] GFC_CHAIN_SYNC_BIT = 5'h10;
  // host register offsets
  localparam logic [1:0] GFC_HOST_CMD_OFS = 2'h0;
  localparam logic [1:0] GFC_HOST_STAT_OFS = 2'h1;
  localparam logic [1:0] GFC_HOST_RESP_OFS = 2'h2;
  localparam logic [1:0] GFC_HOST_PIN_OFS = 2'h3;
  localparam logic [4:0] GFC_HOST_PIN_RST = 5'h00;

  function automatic logic [3:0] gfc_level_db(input logic [2:0] code);
    logic [3:0] db;
    db = 4'h0;
    unique case (code[1:0])
      2'h0: db = 4'h0;
      2'h1: db = 4'h3;
      2'h2: db = 4'h6;
      2'h3: db = 4'h9;
    endcase
    if (code[2])
    begin
      db = 4'hc;
    end
    return db;
  endfunction : gfc_level_db
endpackage : gfc_pkg
`default_nettype wire

// >>> gfc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface gfc_if;
  logic bit_clock;
  logic frame_sync_out;
  logic serial_data_out;
  logic serial_data_in;
  logic line_seize_input_n;
  logic port_mode_select_0;
  logic port_mode_select_1;
  logic ring_or_delayed_sync_pin;
  logic secondary_request_or_ring_pin_dev_out;
  logic secondary_request_or_ring_pin_dev_oe;
  logic secondary_request_or_ring_pin_host_out;
  logic secondary_request_or_ring_pin_host_oe;
  logic secondary_request_or_ring_pin;
  // undriven wire idles high
  assign secondary_request_or_ring_pin =
    secondary_request_or_ring_pin_dev_oe ?
      secondary_request_or_ring_pin_dev_out :
    secondary_request_or_ring_pin_host_oe ?
      secondary_request_or_ring_pin_host_out : 1'b1;

  modport dev (
    output bit_clock,
    output frame_sync_out,
    output serial_data_out,
    input serial_data_in,
    input line_seize_input_n,
    input port_mode_select_0,
    input port_mode_select_1,
    output ring_or_delayed_sync_pin,
    output secondary_request_or_ring_pin_dev_out,
    output secondary_request_or_ring_pin_dev_oe,
    input secondary_request_or_ring_pin
  );
  modport host (
    input bit_clock,
    input frame_sync_out,
    input serial_data_out,
    output serial_data_in,
    output line_seize_input_n,
    output port_mode_select_0,
    output port_mode_select_1,
    input ring_or_delayed_sync_pin,
    output secondary_request_or_ring_pin_host_out,
    output secondary_request_or_ring_pin_host_oe,
    input secondary_request_or_ring_pin
  );
endinterface : gfc_if
`default_nettype wire

// >>> gfc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module gfc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // per bit: a change counts only once two stages agree
      sync_o <= (s2_ff & ~(s2_ff ^ s3_ff)) | (sync_o & (s2_ff ^ s3_ff));
    end
  end
endmodule : gfc_sync
`default_nettype wire

// >>> gfc_host.sv
`timescale 1ns/1ns
`default_nettype none
module gfc_host (
  input wire logic clock_i,
  input wire logic arst_n_i,
  gfc_if.host link,
  input wire logic [1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o
);
  import gfc_pkg::*;

  logic [4:0] pin_s;
  logic sclk_s;
  logic frame_sync_out_s;
  logic sdo_s;
  logic ring_s;
  logic sec_s;
  logic prev_sclk_ff;
  logic [4:0] bit_ff;
  logic [15:0] tx_sh_ff;
  logic [14:0] rx_sh_ff;
  logic [15:0] cmd_ff;
  logic [15:0] resp_ff;
  logic pend_ff;
  logic wait_ff;
  logic due_ff;
  logic [4:0] pins_ff;
  logic seize_n_ff;
  logic host_oe_ff;
  logic rise;
  logic fall;
  logic rx_done;
  logic busy;

  gfc_sync #(.WIDTH(5), .RST_VAL(5'h18)) u_sync (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .async_i({link.ring_or_delayed_sync_pin,
              link.secondary_request_or_ring_pin,
              link.serial_data_out, link.frame_sync_out, link.bit_clock}),
    .sync_o(pin_s)
  );
  assign sclk_s = pin_s[0];
  assign frame_sync_out_s = pin_s[1];
  assign sdo_s = pin_s[2];
  assign sec_s = pin_s[3];
  assign ring_s = pin_s[4];
  assign rise = sclk_s & ~prev_sclk_ff;
  assign fall = ~sclk_s & prev_sclk_ff;
  assign rx_done = fall && (bit_ff == GFC_DATA_LAST);
  assign busy = pend_ff | wait_ff | due_ff;

  // bit clock comes from the device; we follow its edges
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prev_sclk_ff <= 1'b0;
      bit_ff <= GFC_FRAME_LAST;
      tx_sh_ff <= 16'h0000;
      rx_sh_ff <= 15'h0000;
    end
    else
    begin
      prev_sclk_ff <= sclk_s;
      if (rise && frame_sync_out_s)
      begin
        bit_ff <= 5'h00;
        tx_sh_ff <= pend_ff ? cmd_ff : 16'h0000;
      end
      else if (rise)
      begin
        bit_ff <= bit_ff + 5'h01;
        tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
      end
      if (fall && (bit_ff <= GFC_DATA_LAST))
      begin
        rx_sh_ff <= {rx_sh_ff[13:0], sdo_s};
      end
    end
  end

  // command travels in one frame, its answer in the next
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cmd_ff <= 16'h0000;
      resp_ff <= 16'h0000;
      pend_ff <= 1'b0;
      wait_ff <= 1'b0;
      due_ff <= 1'b0;
    end
    else
    begin
      if (wr_i && (addr_i == GFC_HOST_CMD_OFS) && !busy)
      begin
        cmd_ff <= wdata_i;
        pend_ff <= 1'b1;
      end
      if (rise && frame_sync_out_s && pend_ff)
      begin
        pend_ff <= 1'b0;
        wait_ff <= 1'b1;
      end
      if (rx_done && wait_ff)
      begin
        wait_ff <= 1'b0;
        due_ff <= 1'b1;
      end
      if (rx_done && due_ff)
      begin
        resp_ff <= {rx_sh_ff, sdo_s};
        due_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pins_ff <= GFC_HOST_PIN_RST;
      seize_n_ff <= ~GFC_HOST_PIN_RST[0];
      host_oe_ff <= ~GFC_HOST_PIN_RST[4];
    end
    else if (wr_i && (addr_i == GFC_HOST_PIN_OFS))
    begin
      pins_ff <= wdata_i[4:0];
      // pin levels kept in their own flops so no gate sits after them
      seize_n_ff <= ~wdata_i[0];
      host_oe_ff <= ~wdata_i[4];
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o <= 16'h0000;
    end
    else if (rd_i)
    begin
      unique case (addr_i)
        GFC_HOST_CMD_OFS: rdata_o <= cmd_ff;
        GFC_HOST_STAT_OFS: rdata_o <= {13'h0000, ring_s, sec_s, busy};
        GFC_HOST_RESP_OFS: rdata_o <= resp_ff;
        GFC_HOST_PIN_OFS: rdata_o <= {11'h000, pins_ff};
      endcase
    end
    else
    begin
      rdata_o <= 16'h0000;
    end
  end

  assign link.serial_data_in = tx_sh_ff[15];
  assign link.line_seize_input_n = seize_n_ff;
  assign link.port_mode_select_0 = pins_ff[2];
  assign link.port_mode_select_1 = pins_ff[3];
  // drive the shared pin whenever pin bit 4 is clear, whether or not the chain owns it
  assign link.secondary_request_or_ring_pin_host_out = pins_ff[1];
  assign link.secondary_request_or_ring_pin_host_oe = host_oe_ff;
endmodule : gfc_host
`default_nettype wire

// >>> gfc_device.sv
`timescale 1ns/1ns
`default_nettype none
module gfc_device (
  input wire logic clock_i,
  input wire logic arst_n_i,
  gfc_if.dev link,
  input wire logic ring_detect_i,
  input wire logic sleep_req_i,
  output logic tx_muted_o,
  output logic [3:0] tx_atten_db_o,
  output logic rx_muted_o,
  output logic [3:0] rx_gain_db_o,
  output logic iir_select_o,
  output logic cal_start_o,
  output logic auto_cal_en_o,
  output logic sleep_o,
  output logic line_term_o,
  output logic [1:0] port_mode_o,
  output logic secondary_req_o,
  output logic chain_en_o
);
  import gfc_pkg::*;

  logic [4:0] pin_s;
  logic sdi_s;
  logic seize_n_s;
  logic sec_s;
  logic [3:0] div_ff;
  logic sclk_ff;
  logic [4:0] bit_ff;
  logic [4:0] nxt_bit;
  logic frame_sync_out_ff;
  logic sdo_ff;
  logic [15:0] tx_word_ff;
  logic [14:0] rx_sh_ff;
  logic [7:0] rdata_ff;
  logic [7:0] gain_ff;
  logic [1:0] legacy_ff;
  logic [7:0] chain_ff;
  logic iir_ff;
  logic auto_calibrate_disable_ff;
  logic sleep_ff;
  logic ring_pin_ff;
  logic sec_out_ff;
  logic sec_oe_ff;
  logic rise;
  logic fall;
  logic exec;
  logic wr;
  logic [15:0] word;
  logic [7:0] rd_mux;
  logic chain_en;

  // a sleeping device still answers reset: pins stay synchronised
  gfc_sync #(.WIDTH(5), .RST_VAL(5'h06)) u_sync (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .async_i({link.port_mode_select_1, link.port_mode_select_0,
              link.secondary_request_or_ring_pin,
              link.line_seize_input_n, link.serial_data_in}),
    .sync_o(pin_s)
  );
  assign sdi_s = pin_s[0];
  assign seize_n_s = pin_s[1];
  assign sec_s = pin_s[2];

  assign rise = (div_ff == GFC_DIV_LAST) && !sclk_ff;
  assign fall = (div_ff == GFC_DIV_LAST) && sclk_ff;
  assign nxt_bit = bit_ff + 5'h01;
  assign word = {rx_sh_ff, sdi_s};
  assign exec = fall && (bit_ff == GFC_DATA_LAST);
  assign wr = exec && word[15];
  assign chain_en = chain_ff[GFC_CHAIN_BIT];

  // bit clock and frame generation
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      div_ff <= 4'h0;
      sclk_ff <= 1'b0;
      bit_ff <= GFC_FRAME_LAST;
      frame_sync_out_ff <= 1'b0;
      sdo_ff <= 1'b0;
    end
    else
    begin
      div_ff <= div_ff + 4'h1;
      if (div_ff == GFC_DIV_LAST)
      begin
        sclk_ff <= ~sclk_ff;
      end
      if (rise)
      begin
        bit_ff <= nxt_bit;
        frame_sync_out_ff <= (nxt_bit == 5'h00);
        // output data changes on the rising bit clock
        sdo_ff <= (nxt_bit <= GFC_DATA_LAST) ?
          tx_word_ff[GFC_DATA_LAST[3:0] - nxt_bit[3:0]] : 1'b0;
      end
    end
  end

  // input data latched on the falling bit clock
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_sh_ff <= 15'h0000;
    end
    else if (fall && (bit_ff <= GFC_DATA_LAST))
    begin
      rx_sh_ff <= word[14:0];
    end
  end

  always_comb
  begin
    rd_mux = 8'h00;
    unique case (word[14:8])
      GFC_LEGACY_OFS: rd_mux = {6'h00, legacy_ff};
      GFC_CHAIN_OFS: rd_mux = chain_ff;
      GFC_GAIN_OFS: rd_mux = gain_ff;
      GFC_FILTER_OFS: rd_mux = {3'h0, iir_ff, GFC_FILTER_NIBBLE};
      GFC_CAL_OFS: rd_mux = {2'h0, auto_calibrate_disable_ff, 5'h00};
      default: rd_mux = 8'h00;
    endcase
  end

  // answer for a frame goes out at the start of the next one
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_ff <= 8'h00;
      tx_word_ff <= 16'h0000;
    end
    else
    begin
      if (exec)
      begin
        rdata_ff <= rd_mux;
      end
      if (rise && (nxt_bit == 5'h00))
      begin
        tx_word_ff <= {3'h0, sleep_ff, sec_s, ring_detect_i,
                       pin_s[4], pin_s[3], rdata_ff};
      end
    end
  end

  // control registers, all back to defaults under reset
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gain_ff <= GFC_GAIN_RST;
      legacy_ff <= GFC_LEGACY_RST;
      chain_ff <= GFC_CHAIN_RST;
      iir_ff <= GFC_IIR_RST;
      auto_calibrate_disable_ff <= GFC_AUTO_CALIBRATE_DISABLE_RST;
    end
    else if (wr)
    begin
      unique case (word[14:8])
        GFC_LEGACY_OFS: legacy_ff <= word[1:0];
        GFC_CHAIN_OFS: chain_ff <= word[7:0];
        GFC_GAIN_OFS: gain_ff <= word[7:0];
        // only the select bit is stored; fixed bits ignore writes
        GFC_FILTER_OFS: iir_ff <= word[GFC_IIR_BIT];
        GFC_CAL_OFS: auto_calibrate_disable_ff <= word[GFC_AUTO_CALIBRATE_DISABLE_BIT];
        default: ;
      endcase
    end
  end

  // outputs registered so the analog side never sees decode glitches
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_muted_o <= 1'b0;
      tx_atten_db_o <= 4'h0;
      rx_muted_o <= 1'b0;
      rx_gain_db_o <= 4'h0;
      iir_select_o <= 1'b0;
      cal_start_o <= 1'b0;
      auto_cal_en_o <= 1'b1;
      line_term_o <= 1'b0;
      port_mode_o <= 2'h0;
      secondary_req_o <= 1'b0;
      chain_en_o <= 1'b0;
    end
    else
    begin
      tx_muted_o <= gain_ff[GFC_TXM_BIT];
      tx_atten_db_o <= gfc_level_db(gain_ff[6:4]);
      rx_muted_o <= gain_ff[GFC_RXM_BIT];
      rx_gain_db_o <= gfc_level_db(gain_ff[2:0]);
      iir_select_o <= iir_ff;
      // manual calibrate is a one-cycle start, it reads back zero
      cal_start_o <= wr && (word[14:8] == GFC_CAL_OFS) &&
                     word[GFC_MANUAL_CALIBRATE_BIT_BIT];
      auto_cal_en_o <= ~auto_calibrate_disable_ff;
      line_term_o <= ~seize_n_s;
      port_mode_o <= pin_s[4:3];
      secondary_req_o <= ~chain_en && sec_s;
      chain_en_o <= chain_en;
    end
  end

  // reset clears sleep, which is the only way out of it
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sleep_ff <= 1'b0;
    end
    else if (sleep_req_i)
    begin
      sleep_ff <= 1'b1;
    end
  end

  // shared pins switch role with chain enable
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ring_pin_ff <= 1'b1;
      sec_out_ff <= 1'b1;
      sec_oe_ff <= 1'b0;
    end
    else
    begin
      sec_oe_ff <= chain_en;
      sec_out_ff <= ~ring_detect_i;
      if (chain_en)
      begin
        ring_pin_ff <= frame_sync_out_ff ? 1'b0 :
          (rise && (nxt_bit == GFC_CHAIN_SYNC_BIT)) ? 1'b1 :
          (rise && (nxt_bit == GFC_CHAIN_SYNC_BIT + 5'h01)) ? 1'b0 :
          ring_pin_ff;
      end
      else
      begin
        ring_pin_ff <= ~ring_detect_i;
      end
    end
  end

  assign sleep_o = sleep_ff;
  assign link.bit_clock = sclk_ff;
  assign link.frame_sync_out = frame_sync_out_ff;
  assign link.serial_data_out = sdo_ff;
  assign link.ring_or_delayed_sync_pin = ring_pin_ff;
  assign link.secondary_request_or_ring_pin_dev_out = sec_out_ff;
  assign link.secondary_request_or_ring_pin_dev_oe = sec_oe_ff;
endmodule : gfc_device
`default_nettype wire

// >>> gfc_props.sv
`timescale 1ns/1ns
`default_nettype none
module gfc_props (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic bit_clock,
  input wire logic frame_sync_out,
  input wire logic serial_data_out,
  input wire logic line_seize_input_n,
  input wire logic ring_or_delayed_sync_pin,
  input wire logic secondary_request_or_ring_pin_dev_oe,
  input wire logic secondary_request_or_ring_pin_host_oe
);
  logic bclk_prev_ff, bclk_seen_ff, fs_prev_ff, fs_seen_ff, fs_rise, dev_oe;
  logic [4:0] bclk_run_ff;
  logic [10:0] frame_pos_ff;
  assign fs_rise = frame_sync_out && !fs_prev_ff;
  assign dev_oe = secondary_request_or_ring_pin_dev_oe;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);
  // counters measure runs of the link waveform from its own edges
  always_ff @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      bclk_prev_ff <= 1'b0;
      bclk_seen_ff <= 1'b0;
      bclk_run_ff <= 5'h00;
      fs_prev_ff <= 1'b0;
      fs_seen_ff <= 1'b0;
      frame_pos_ff <= 11'h000;
    end
    else
    begin
      bclk_prev_ff <= bit_clock;
      bclk_seen_ff <= bclk_seen_ff || (bit_clock != bclk_prev_ff);
      bclk_run_ff <= (bit_clock != bclk_prev_ff) ? 5'h00 : bclk_run_ff + 5'h01;
      fs_prev_ff <= frame_sync_out;
      fs_seen_ff <= fs_seen_ff || fs_rise;
      // saturates so a stuck sync cannot wrap into a legal count
      frame_pos_ff <= fs_rise ? 11'h000 : (frame_pos_ff == 11'h7ff) ?
        frame_pos_ff : frame_pos_ff + 11'h001;
    end
  AST_BCLK_HALF: assert property (
    bclk_seen_ff |-> ((bit_clock != bclk_prev_ff) ?
      bclk_run_ff == 5'h0f : bclk_run_ff < 5'h0f))
    else $error("bit clock half period is not 16 clocks");
  AST_FRAME_SYNC_OUT_WIDTH: assert property (
    !frame_sync_out && fs_prev_ff |-> frame_pos_ff == 11'h01f)
    else $error("frame sync not high for one bit clock");
  AST_FRAME_PERIOD: assert property (
    fs_rise && fs_seen_ff |-> frame_pos_ff == 11'h3ff)
    else $error("frame period is not 1024 clocks");
  AST_SDO_LOW_PHASE: assert property (
    !bit_clock && !$past(bit_clock) && !$past(bit_clock, 2)
      |-> $stable(serial_data_out))
    else $error("serial output moved inside low bit clock phase");
  AST_SDO_IDLE: assert property (
    fs_seen_ff && frame_pos_ff inside {[11'h208:11'h3fa]}
      |-> !serial_data_out)
    else $error("serial output not idle after bit 15");
  AST_RESET_VALUES: assert property (
    $rose(arst_n_i) |-> !bit_clock && !frame_sync_out && !serial_data_out
      && line_seize_input_n && !dev_oe)
    else $error("link not at initial levels after reset");
  AST_ONE_DRIVER: assert property (
    !(dev_oe && secondary_request_or_ring_pin_host_oe))
    else $error("both ends drive the request pin");
  AST_CHAIN_SWITCH: assert property (
    fs_seen_ff && $changed(dev_oe) |-> frame_pos_ff inside {[11'h1e8:11'h1fa]})
    else $error("chain switch not at end of command bits");
  AST_CHAIN_SYNC_LOW: assert property (
    frame_sync_out && $past(frame_sync_out) && dev_oe && $past(dev_oe)
      |-> !ring_or_delayed_sync_pin)
    else $error("delayed sync high during frame sync");
  AST_DELAYED_SYNC: assert property (
    fs_rise && dev_oe |-> ##[510:516] (ring_or_delayed_sync_pin || !dev_oe))
    else $error("delayed sync missing half a frame later");
  cover property ($rose(dev_oe));
  cover property (fs_rise && dev_oe);
  cover property (!line_seize_input_n);
endmodule : gfc_props
`default_nettype wire

// >>> gain_filter_cal_control_test.sv
`timescale 1ns/1ns
`default_nettype none
module gain_filter_cal_control_test;
  import gfc_pkg::*;
  logic clock_i, arst_n_i, wr_i, rd_i, ring_detect_i, sleep_req_i;
  logic [1:0] addr_i, port_mode_o;
  logic [15:0] wdata_i, rdata_o, resp, s;
  logic tx_muted_o, rx_muted_o, iir_select_o, cal_start_o, auto_cal_en_o;
  logic sleep_o, line_term_o, secondary_req_o, chain_en_o;
  logic [3:0] tx_atten_db_o, rx_gain_db_o;
  logic [7:0] g, prev;
  int n_fail, tests_run, cycles, n_cal, c0, i;
  gfc_if link_if();
  gfc_host i_gfc_host (.clock_i(clock_i), .arst_n_i(arst_n_i), .link(link_if),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o));
  gfc_device i_gfc_device (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .link(link_if), .ring_detect_i(ring_detect_i), .sleep_req_i(sleep_req_i),
    .tx_muted_o(tx_muted_o), .tx_atten_db_o(tx_atten_db_o),
    .rx_muted_o(rx_muted_o), .rx_gain_db_o(rx_gain_db_o),
    .iir_select_o(iir_select_o), .cal_start_o(cal_start_o),
    .auto_cal_en_o(auto_cal_en_o), .sleep_o(sleep_o),
    .line_term_o(line_term_o), .port_mode_o(port_mode_o),
    .secondary_req_o(secondary_req_o), .chain_en_o(chain_en_o));
  gfc_props i_gfc_props (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .bit_clock(link_if.bit_clock), .frame_sync_out(link_if.frame_sync_out),
    .serial_data_out(link_if.serial_data_out),
    .line_seize_input_n(link_if.line_seize_input_n),
    .ring_or_delayed_sync_pin(link_if.ring_or_delayed_sync_pin),
    .secondary_request_or_ring_pin_dev_oe(
      link_if.secondary_request_or_ring_pin_dev_oe),
    .secondary_request_or_ring_pin_host_oe(
      link_if.secondary_request_or_ring_pin_host_oe));
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  function automatic logic [3:0] db_of(input logic [2:0] c);
    return c[2] ? 4'hc : 4'(3 * c[1:0]);
  endfunction : db_of
  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // trailing idle edge keeps two writes from landing in one time step
  task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask : bus_wr
  task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    d = rdata_o;
    @(posedge clock_i);
  endtask : bus_rd
  // reply comes two frames later, so poll busy with a bound
  task automatic dev_cmd(input logic w, input logic [6:0] a,
    input logic [7:0] d, output logic [15:0] r);
    logic [15:0] st;
    int k;
    bus_wr(GFC_HOST_CMD_OFS, {w, a, d});
    st = 16'h0001;
    for (k = 0; k < 3000 && st[0] !== 1'b0; k++)
      bus_rd(GFC_HOST_STAT_OFS, st);
    check(16'(st[0]), 16'h0000);
    bus_rd(GFC_HOST_RESP_OFS, r);
  endtask : dev_cmd
  task automatic dev_rd(input logic [6:0] a, input logic [7:0] exp);
    dev_cmd(1'b0, a, 8'h00, resp);
    check(16'(resp[7:0]), 16'(exp));
  endtask : dev_rd
  task automatic do_reset();
    arst_n_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
  endtask : do_reset
  task automatic check_rst();
    check(16'({tx_muted_o, tx_atten_db_o, rx_muted_o, rx_gain_db_o}),
      16'h0000);
    check(16'({iir_select_o, auto_cal_en_o, sleep_o, chain_en_o}),
      16'h0004);
    dev_rd(GFC_FILTER_OFS, 8'h08);
    dev_rd(GFC_CAL_OFS, 8'h00);
    dev_rd(GFC_GAIN_OFS, 8'h00);
  endtask : check_rst
  always @(posedge clock_i)
  begin
    if (cal_start_o === 1'b1)
      n_cal <= n_cal + 1;
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      n_fail = n_fail + 1;
      report_and_stop();
    end
  end
  initial
  begin
    {addr_i, wdata_i, wr_i, rd_i, ring_detect_i, sleep_req_i} = '0;
    {n_fail, tests_run, cycles, n_cal} = '0;
    arst_n_i = 1'b0;
    do_reset();
    check_rst();
    dev_cmd(1'b1, GFC_LEGACY_OFS, 8'h00, resp);
    prev = 8'h00;
    // every code on both paths, mute toggling each step
    for (i = 0; i < 8; i++)
    begin
      g = {i[0], i[2:0], ~i[0], 3'(7 - i)};
      dev_cmd(1'b1, GFC_GAIN_OFS, g, resp);
      check(16'(resp[7:0]), 16'(prev));
      check(16'({tx_muted_o, rx_muted_o}), 16'({g[7], g[3]}));
      check(16'({tx_atten_db_o, rx_gain_db_o}),
        {8'h00, db_of(g[6:4]), db_of(g[2:0])});
      prev = g;
    end
    dev_cmd(1'b1, GFC_FILTER_OFS, 8'h18, resp);
    check(16'(iir_select_o), 16'h0001);
    // software keeps the fixed bits at their documented pattern
    dev_cmd(1'b1, GFC_FILTER_OFS, 8'h08, resp);
    check(16'(resp[7:0]), 16'h0018);
    check(16'(iir_select_o), 16'h0000);
    dev_cmd(1'b1, GFC_FILTER_OFS, 8'h08, resp);
    check(16'(resp[7:0]), 16'h0008);
    c0 = n_cal;
    dev_cmd(1'b1, GFC_CAL_OFS, 8'h60, resp);
    check(16'(n_cal - c0), 16'h0001);
    check(16'(auto_cal_en_o), 16'h0000);
    dev_cmd(1'b1, GFC_CAL_OFS, 8'h00, resp);
    check(16'(resp[7:0]), 16'h0020);
    check(16'(auto_cal_en_o), 16'h0001);
    check(16'(n_cal - c0), 16'h0001);
    ring_detect_i <= 1'b1;
    bus_wr(GFC_HOST_PIN_OFS, 16'h000b);
    repeat (8) @(posedge clock_i);
    check(16'({line_term_o, secondary_req_o, port_mode_o}),
      16'h000e);
    bus_rd(GFC_HOST_STAT_OFS, s);
    check(16'(s[2:1]), 16'h0001);
    dev_cmd(1'b0, GFC_GAIN_OFS, 8'h00, resp);
    check(16'(resp[9:8]), 16'h0002);
    ring_detect_i <= 1'b0;
    bus_wr(GFC_HOST_PIN_OFS, 16'h0004);
    repeat (8) @(posedge clock_i);
    check(16'({line_term_o, secondary_req_o, port_mode_o}),
      16'h0001);
    bus_rd(GFC_HOST_STAT_OFS, s);
    check(16'(s[2:1]), 16'h0002);
    // host lets go of the request pin before the device takes it
    bus_wr(GFC_HOST_PIN_OFS, 16'h0010);
    dev_cmd(1'b1, GFC_CHAIN_OFS, 8'h03, resp);
    check(16'(chain_en_o), 16'h0001);
    ring_detect_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    bus_rd(GFC_HOST_STAT_OFS, s);
    check(16'(s[1]), 16'h0000);
    ring_detect_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    bus_rd(GFC_HOST_STAT_OFS, s);
    check(16'(s[1]), 16'h0001);
    dev_cmd(1'b1, GFC_CHAIN_OFS, 8'h02, resp);
    check(16'(chain_en_o), 16'h0000);
    bus_wr(GFC_HOST_PIN_OFS, 16'h0000);
    sleep_req_i <= 1'b1;
    @(posedge clock_i);
    sleep_req_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    check(16'(sleep_o), 16'h0001);
    dev_cmd(1'b1, GFC_FILTER_OFS, 8'h18, resp);
    do_reset();
    check_rst();
    report_and_stop();
  end
endmodule : gain_filter_cal_control_test
`default_nettype wire
